// ==== verilog/bmsq_pkg.sv ====
// boost sequencer shared constants, states and register map
// assumes a 40 MHz switching oscillator clock
package bmsq_pkg;
    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam int CLK_HZ      = 40_000_000;       // sequencer clock
    localparam int SW_HZ       = 600_000;          // nominal switching rate
    localparam int PWM_PER     = CLK_HZ / SW_HZ;   // clocks per period, rounded down
    localparam int US_CYC      = CLK_HZ / 1_000_000;
    localparam int SS_TIME_US  = 2000;             // soft start ramp time
    localparam int HIC_TIME_US = 1000;             // hiccup off time
    localparam int SS_CYC      = SS_TIME_US * US_CYC;
    localparam int HIC_CYC     = HIC_TIME_US * US_CYC;
    localparam logic [7:0] PER_LAST    = 8'(PWM_PER - 1);     // fixed rate
    localparam logic [7:0] PER_LAST_LL = 8'(2 * PWM_PER - 1); // stretched rate
    // ----------------------------------------
    // reference code
    // ----------------------------------------
    localparam int CODE_W = 10;
    localparam logic [CODE_W-1:0] REF_FULL = 10'h3ff;   // code of 0.8 V
    localparam logic [CODE_W-1:0] CODE_ONE = 10'h001;
    // ----------------------------------------
    // register map and fields
    // ----------------------------------------
    localparam int ADDR_W = 4;
    localparam logic [ADDR_W-1:0] A_CTRL  = 4'h0;  // control
    localparam logic [ADDR_W-1:0] A_STAT  = 4'h4;  // live status
    localparam logic [ADDR_W-1:0] A_FAULT = 4'h8;  // sticky faults, write 1 clears
    localparam int CTRL_LL_BIT = 0;                // allow light load mode
    localparam logic CTRL_LL_RST = 1'b1;
    localparam int F_SHORT = 0;
    localparam int F_OVER  = 1;
    localparam int F_HOT   = 2;
    localparam int NFAULT  = 3;
    // ----------------------------------------
    // synchronised comparator vector indices
    // ----------------------------------------
    localparam int I_EN = 0, I_SUP = 1, I_EXIT = 2, I_CMP = 3, I_LIM = 4, I_MARG = 5;
    localparam int I_BELOW = 6, I_OVER = 7, I_HOT = 8, I_LL = 9, I_SKIP = 10;
    localparam int I_BLOW = 11, I_BFLAG = 12, NSYNC = 13;
    // ----------------------------------------
    // sequencer states, gray along start path
    // ----------------------------------------
    typedef enum logic [2:0] {
        S_OFF  = 3'h0,
        S_LOCK = 3'h1,
        S_PRE  = 3'h3,
        S_SOFT = 3'h2,
        S_RUN  = 3'h6,
        S_HIC  = 3'h7
    } bmsq_state_e;
endpackage

// ==== verilog/bmsq_ramp_if.sv ====
// sequencer to soft start ramp connection
// assumes one clock domain shared by both ends
`timescale 1ns/1ps
`default_nettype none
interface bmsq_ramp_if;
    import bmsq_pkg::*;
    logic              track;     // ramp follows feedback
    logic              run;       // ramp may climb
    logic [CODE_W-1:0] feedback;  // sampled feedback code
    logic [CODE_W-1:0] code;      // soft start level
    logic              done;      // level at final value
    modport ctl (output track, run, feedback, input code, done);
    modport rmp (input track, run, feedback, output code, done);
endinterface
`default_nettype wire

// ==== verilog/bmsq_sync.sv ====
// two flip-flop synchroniser for a vector of comparator levels
// assumes each bit is an independent slow level
`timescale 1ns/1ps
`default_nettype none
module bmsq_sync #(
    parameter int W = 1
) (
    input  wire logic         sys_clk_in,
    input  wire logic         rstn_in,
    input  wire logic [W-1:0] d_in,
    output logic      [W-1:0] q_out
);
    logic [W-1:0] s1_r;   // first stage, read only by second
    logic [W-1:0] s2_r;   // second stage
    // ----------------------------------------
    // two stages
    // ----------------------------------------
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            s1_r <= '0;
            s2_r <= '0;
        end else begin
            s1_r <= d_in;
            s2_r <= s1_r;
        end
    end
    assign q_out = s2_r;
endmodule
`default_nettype wire

// ==== verilog/bmsq_ramp.sv ====
// soft start level generator feeding the reference code
// assumes track and run are never high together
`timescale 1ns/1ps
`default_nettype none
module bmsq_ramp #(
    parameter int STEP_P = 78   // clocks per code step
) (
    input  wire logic sys_clk_in,
    input  wire logic rstn_in,
    bmsq_ramp_if.rmp  rif
);
    import bmsq_pkg::*;
    logic [CODE_W-1:0] code_r, code_nxt;   // soft start level
    logic [31:0]       cnt_r, cnt_nxt;     // step prescaler
    // ----------------------------------------
    // next level
    // ----------------------------------------
    always_comb begin
        code_nxt = code_r;
        cnt_nxt  = cnt_r;
        if (rif.track) begin
            // follow feedback while charging linearly
            code_nxt = rif.feedback;
            cnt_nxt  = '0;
        end else if (rif.run && code_r != REF_FULL) begin
            // slow climb from the tracked level
            if (cnt_r == 32'(STEP_P - 1)) begin
                code_nxt = code_r + CODE_ONE;
                cnt_nxt  = '0;
            end else begin
                cnt_nxt = cnt_r + 32'h0000_0001;
            end
        end
    end
    // ----------------------------------------
    // registers
    // ----------------------------------------
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            code_r <= '0;
            cnt_r  <= '0;
        end else begin
            code_r <= code_nxt;
            cnt_r  <= cnt_nxt;
        end
    end
    assign rif.code = code_r;
    assign rif.done = (code_r == REF_FULL);   // ends at final level
endmodule
`default_nettype wire

// ==== verilog/bmsq_top.sv ====
// boost converter mode sequencer: enable, start-up, modulation, protection
// assumes comparator levels from the analog side, asynchronous to the clock
//
// Function
// - chip-on pin high means enable request
// - chip-on low: stop, power down, isolate
// - bias starts after supply lockout rises
// - linear precharge first, switch at exit level
// - precharge current grows with output voltage
// - soft start tracks feedback, then ramps slowly
// - reference ramps with soft start level
// - soft start ends at final level
// - heavy load: fixed frequency peak current modulation
// - light load mode entered and left automatically
// - low-side on at start, off at error level
// - light load: lower rate, then skip pulses
// - step-down mode when output below input margin
// - peak limit cuts low-side in same cycle
// - limit with output below input: short fault
// - short fault: stop, wait, restart from scratch
// - shut down: block high-side body diode
// - overvoltage: both switches off
// - overvoltage cleared: switching resumes itself
// - battery flag only while enabled, else released
// - battery flag low below threshold, else released
// - overtemperature stops switching until cooled
`timescale 1ns/1ps
`default_nettype none
module bmsq_top #(
    parameter int SS_CYC_P  = bmsq_pkg::SS_CYC,   // soft start clocks
    parameter int HIC_CYC_P = bmsq_pkg::HIC_CYC   // hiccup wait clocks
) (
    input  wire logic                        sys_clk_in,
    input  wire logic                        rstn_in,
    input  wire logic                        chip_on_in,
    input  wire logic                        supply_lockout_rising_in,
    input  wire logic                        out_exit_level_in,
    input  wire logic                        error_amp_level_in,
    input  wire logic                        peak_limit_in,
    input  wire logic                        below_margin_in,
    input  wire logic                        below_input_in,
    input  wire logic                        overvoltage_guard_in,
    input  wire logic                        thermal_hot_in,
    input  wire logic                        light_load_in,
    input  wire logic                        skip_load_in,
    input  wire logic                        battery_sense_input_in,
    input  wire logic                        battery_low_flag_in,
    input  wire logic [bmsq_pkg::CODE_W-1:0] regulation_feedback_in,
    input  wire logic [bmsq_pkg::ADDR_W-1:0] addr_in,
    input  wire logic [31:0]                 wdata_in,
    input  wire logic                        wr_in,
    input  wire logic                        rd_in,
    output logic      [31:0]                 rdata_out,
    output logic                             bias_en_out,
    output logic                             precharge_out,
    output logic                             ss_track_out,
    output logic      [bmsq_pkg::CODE_W-1:0] ref_code_out,
    output logic                             ls_on_out,
    output logic                             hs_on_out,
    output logic                             step_down_out,
    output logic                             hs_body_block_out,
    output logic                             light_load_mode_out,
    output logic                             battery_low_flag_out,
    output logic                             battery_low_flag_oe_out
);
    import bmsq_pkg::*;

    // ----------------------------------------
    // derived constants
    // ----------------------------------------
    localparam int SS_STEP = (SS_CYC_P / (1 << CODE_W) > 0) ?
                             SS_CYC_P / (1 << CODE_W) : 1;

    // ----------------------------------------
    // declarations
    // ----------------------------------------
    logic [NSYNC-1:0]  raw;               // comparator levels as seen
    logic [NSYNC-1:0]  syn;               // after two flops
    bmsq_state_e       st_r, st_nxt;      // sequencer state
    logic [31:0]       hic_r, hic_nxt;    // hiccup wait count
    logic [7:0]        per_r, per_nxt;    // modulation period count
    logic [7:0]        per_last;          // last count of period
    logic              ls_r, ls_nxt;      // low-side gate
    logic              hs_r, hs_nxt;      // high-side gate
    logic              light_r, light_nxt;
    logic              step_r, step_nxt;
    logic              lbo_r, lbo_nxt;    // battery flag pull-down
    logic              ctrl_r, ctrl_nxt;  // light load allowed
    logic [NFAULT-1:0] fault_r, fault_nxt;
    logic [31:0]       rdata_r, rdata_nxt;
    logic [31:0]       stat;              // live status word
    logic              en, switching, run_ok, short_hit, per_end;

    bmsq_ramp_if ramp_if ();

    // ----------------------------------------
    // input synchronisers
    // ----------------------------------------
    assign raw = {battery_low_flag_in, battery_sense_input_in, skip_load_in,
                  light_load_in, thermal_hot_in, overvoltage_guard_in,
                  below_input_in, below_margin_in, peak_limit_in,
                  error_amp_level_in, out_exit_level_in,
                  supply_lockout_rising_in, chip_on_in};

    // every comparator passes two flops
    bmsq_sync #(
        .W          (NSYNC)
    ) u_sync (
        .sys_clk_in (sys_clk_in),
        .rstn_in    (rstn_in),
        .d_in       (raw),
        .q_out      (syn)
    );

    // ----------------------------------------
    // soft start ramp
    // ----------------------------------------
    bmsq_ramp #(
        .STEP_P     (SS_STEP)
    ) u_ramp (
        .sys_clk_in (sys_clk_in),
        .rstn_in    (rstn_in),
        .rif        (ramp_if.rmp)
    );

    assign ramp_if.feedback = regulation_feedback_in;
    assign ramp_if.track    = !switching;   // follow feedback until switching
    assign ramp_if.run      = switching;

    // ----------------------------------------
    // shared decodes
    // ----------------------------------------
    assign en        = syn[I_EN];                  // enable request
    assign switching = (st_r == S_SOFT) || (st_r == S_RUN);
    // overvoltage and heat only gate, so release resumes
    assign run_ok    = switching && en && !short_hit && !syn[I_OVER] && !syn[I_HOT];
    assign short_hit = syn[I_LIM] && syn[I_BELOW];
    assign per_last  = light_r ? PER_LAST_LL : PER_LAST;
    assign per_end   = (per_r == per_last);

    // ----------------------------------------
    // sequencer next state
    // ----------------------------------------
    always_comb begin
        st_nxt  = st_r;
        hic_nxt = hic_r;
        case (st_r)
            S_OFF: begin
                if (en) begin
                    st_nxt = S_LOCK;
                end
            end
            S_LOCK: begin
                // bias waits for rising lockout level
                if (syn[I_SUP]) begin
                    st_nxt = S_PRE;
                end
            end
            S_PRE: begin
                // leave linear charge at exit level
                if (syn[I_EXIT]) begin
                    st_nxt = S_SOFT;
                end
            end
            S_SOFT: begin
                if (short_hit) begin
                    st_nxt = S_HIC;
                end else if (ramp_if.done) begin
                    st_nxt = S_RUN;
                end
            end
            S_RUN: begin
                if (short_hit) begin
                    st_nxt = S_HIC;
                end
            end
            S_HIC: begin
                // wait, then a fresh power-on pass
                if (hic_r == 32'(HIC_CYC_P - 1)) begin
                    hic_nxt = '0;
                    st_nxt  = S_LOCK;
                end else begin
                    hic_nxt = hic_r + 32'h0000_0001;
                end
            end
            default: begin
                st_nxt = S_OFF;
            end
        endcase
        // chip-on low overrides everything
        if (!en) begin
            st_nxt  = S_OFF;
            hic_nxt = '0;
        end
    end

    // ----------------------------------------
    // modulation next state
    // ----------------------------------------
    always_comb begin
        per_nxt   = per_end ? 8'h00 : per_r + 8'h01;
        ls_nxt    = ls_r;
        hs_nxt    = hs_r;
        light_nxt = light_r;
        if (per_end) begin
            // mode change at a period edge, or at once on leaving run
            light_nxt = syn[I_LL] && ctrl_r && (st_r == S_RUN);
        end
        if (st_r != S_RUN) begin
            light_nxt = 1'b0;
        end
        if (!run_ok) begin
            // stop, overvoltage or heat: both off
            ls_nxt = 1'b0;
            hs_nxt = 1'b0;
        end else if (per_end) begin
            if (light_r && syn[I_SKIP]) begin
                ls_nxt = 1'b0;           // skipped pulse
                hs_nxt = 1'b0;
            end else begin
                ls_nxt = 1'b1;           // period opens low-side
                hs_nxt = 1'b0;
            end
        end else if (ls_r && (syn[I_CMP] || syn[I_LIM])) begin
            // error level or peak limit ends on-time
            ls_nxt = 1'b0;
            hs_nxt = 1'b1;
        end
        step_nxt = switching && syn[I_MARG];
        lbo_nxt  = en && syn[I_BLOW];
    end

    // ----------------------------------------
    // register file next state
    // ----------------------------------------
    assign stat = {23'h00_0000, syn[I_BFLAG], lbo_r, light_r, step_r,
                   syn[I_HOT], syn[I_OVER], st_r};

    always_comb begin
        ctrl_nxt  = ctrl_r;
        fault_nxt = fault_r;
        rdata_nxt = 32'h0000_0000;
        if (wr_in) begin
            if (addr_in == A_CTRL) begin
                ctrl_nxt = wdata_in[CTRL_LL_BIT];
            end else if (addr_in == A_FAULT) begin
                fault_nxt = fault_r & ~wdata_in[NFAULT-1:0];
            end
        end
        // set after clear so a same-cycle event survives
        fault_nxt[F_SHORT] = fault_nxt[F_SHORT] | (switching && short_hit);
        fault_nxt[F_OVER]  = fault_nxt[F_OVER] | (switching && syn[I_OVER]);
        fault_nxt[F_HOT]   = fault_nxt[F_HOT] | (en && syn[I_HOT]);
        if (rd_in) begin
            if (addr_in == A_CTRL) begin
                rdata_nxt = {31'h0000_0000, ctrl_r};
            end else if (addr_in == A_STAT) begin
                rdata_nxt = stat;
            end else if (addr_in == A_FAULT) begin
                rdata_nxt = {29'h0000_0000, fault_r};
            end
        end
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            st_r    <= S_OFF;
            hic_r   <= '0;
            per_r   <= '0;
            ls_r    <= 1'b0;
            hs_r    <= 1'b0;
            light_r <= 1'b0;
            step_r  <= 1'b0;
            lbo_r   <= 1'b0;
            ctrl_r  <= CTRL_LL_RST;
            fault_r <= '0;
            rdata_r <= '0;
        end else begin
            st_r    <= st_nxt;
            hic_r   <= hic_nxt;
            per_r   <= per_nxt;
            ls_r    <= ls_nxt;
            hs_r    <= hs_nxt;
            light_r <= light_nxt;
            step_r  <= step_nxt;
            lbo_r   <= lbo_nxt;
            ctrl_r  <= ctrl_nxt;
            fault_r <= fault_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign bias_en_out   = (st_r != S_OFF) && (st_r != S_LOCK);
    // current-regulated rectifier charge, analog sets slope
    assign precharge_out = (st_r == S_PRE);
    assign ss_track_out  = ramp_if.track;
    assign ref_code_out  = ramp_if.code;     // reference equals ramp
    assign ls_on_out     = ls_r;
    assign hs_on_out     = hs_r;
    assign step_down_out = step_r;
    // disconnect while off or locked out
    assign hs_body_block_out   = (st_r == S_OFF) || (st_r == S_LOCK);
    assign light_load_mode_out = light_r;
    assign battery_low_flag_out    = 1'b0;   // open drain, pulls low only
    assign battery_low_flag_oe_out = lbo_r;
    assign rdata_out = rdata_r;

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rstn_in);

    property p_off_quiet;
        !en |=> (st_r == S_OFF) && !ls_r && !hs_r;
    endproperty
    a_off_quiet: assert property (p_off_quiet) else $error("not quiet when off");

    property p_lock_hold;
        (st_r == S_LOCK) && en && !syn[I_SUP] |=> (st_r == S_LOCK) && !bias_en_out;
    endproperty
    a_lock_hold: assert property (p_lock_hold) else $error("bias before lockout");

    property p_pre_exit;
        (st_r == S_PRE) && en && syn[I_EXIT] |=> (st_r == S_SOFT) && !ss_track_out;
    endproperty
    a_pre_exit: assert property (p_pre_exit) else $error("precharge exit wrong");

    property p_ls_cut;
        ls_r && syn[I_LIM] && !per_end |=> !ls_r;
    endproperty
    a_ls_cut: assert property (p_ls_cut) else $error("limit missed");

    property p_ls_start;
        $rose(ls_r) |-> $past(per_end) && $past(run_ok) && !hs_r;
    endproperty
    a_ls_start: assert property (p_ls_start) else $error("on-time off period edge");

    property p_over_off;
        syn[I_OVER] |=> !ls_r && !hs_r;
    endproperty
    a_over_off: assert property (p_over_off) else $error("switching in overvoltage");

    property p_hot_off;
        syn[I_HOT] ##1 syn[I_HOT] |-> !ls_r && !hs_r;
    endproperty
    a_hot_off: assert property (p_hot_off) else $error("switching while hot");

    property p_short;
        switching && en && short_hit |=> (st_r == S_HIC) && !ls_r;
    endproperty
    a_short: assert property (p_short) else $error("short fault missed");

    property p_hic_wait;
        $rose(st_r == S_HIC) |-> ((st_r == S_HIC) || (st_r == S_OFF))[*8];
    endproperty
    a_hic_wait: assert property (p_hic_wait) else $error("hiccup wait cut short");

    property p_flag_off;
        !en |=> !battery_low_flag_oe_out;
    endproperty
    a_flag_off: assert property (p_flag_off) else $error("flag driven while off");

    property p_block;
        (st_r == S_OFF) |-> hs_body_block_out && !hs_r;
    endproperty
    a_block: assert property (p_block) else $error("no disconnect when off");

    c_run: cover property ((st_r == S_SOFT) ##1 (st_r == S_RUN));
    c_hic: cover property ((st_r == S_HIC) ##1 (st_r == S_LOCK));
    c_light: cover property ($rose(light_r));
    c_flag: cover property ($rose(battery_low_flag_oe_out));
endmodule
`default_nettype wire

// ==== verif/bmsq_analog.sv ====
// analog side model: output charge, feedback code and current comparator
// assumes the sequencer clock; output level never discharges
`timescale 1ns/1ps
`default_nettype none
module bmsq_analog (
    input  wire logic       sys_clk_in,
    input  wire logic       precharge_in,
    input  wire logic       ls_on_in,
    input  wire logic [5:0] cmp_dly_in,
    output logic            exit_out,
    output logic            cmp_out,
    output logic [9:0]      fb_out
);
    logic [9:0] vout_r = 10'h000; // output level code
    logic [5:0] on_r   = 6'h00;   // low-side on time
    // output climbs only while precharging
    always @(posedge sys_clk_in) begin
        if (precharge_in) vout_r <= vout_r + 10'h001;
        on_r <= ls_on_in ? on_r + 6'h01 : 6'h00;
    end
    assign exit_out = vout_r >= 10'h040;
    assign cmp_out  = ls_on_in && (on_r >= cmp_dly_in); // current meets error level
    assign fb_out   = vout_r;
endmodule
`default_nettype wire

// ==== verif/bmsq_top_tb.sv ====
// self-checking bench for the boost sequencer
// assumes the analog model and shortened soft start and hiccup counts
`timescale 1ns/1ps
`default_nettype none
module bmsq_top_tb;
    logic sys_clk_in = 1'b0, rstn_in = 1'b0, chip_on_in = 1'b0, supply_lockout_rising_in = 1'b0;
    logic peak_limit_in = 1'b0, below_margin_in = 1'b0, below_input_in = 1'b0;
    logic overvoltage_guard_in = 1'b0, thermal_hot_in = 1'b0, light_load_in = 1'b0;
    logic skip_load_in = 1'b0, battery_sense_input_in = 1'b0, wr_in = 1'b0, rd_in = 1'b0;
    logic [3:0] addr_in = 4'h0;
    logic [31:0] wdata_in = 32'h0000_0000, rdata_out;
    logic out_exit_level_in, error_amp_level_in, battery_low_flag_in, hs_seen;
    logic [9:0] regulation_feedback_in, ref_code_out;
    logic bias_en_out, precharge_out, ss_track_out, ls_on_out, hs_on_out, step_down_out;
    logic hs_body_block_out, light_load_mode_out, battery_low_flag_out, battery_low_flag_oe_out;
    logic [5:0] dly = 6'h0a; // comparator trip time
    int bad_count = 0, checks = 0, n, on, per;
    // open-drain flag pin with pull-up
    assign battery_low_flag_in = battery_low_flag_oe_out ? battery_low_flag_out : 1'b1;
    always #12.5 sys_clk_in = ~sys_clk_in;
    bmsq_top #(.SS_CYC_P(2048), .HIC_CYC_P(16)) dut_u (.sys_clk_in, .rstn_in, .chip_on_in,
        .supply_lockout_rising_in, .out_exit_level_in, .error_amp_level_in, .peak_limit_in,
        .below_margin_in, .below_input_in, .overvoltage_guard_in, .thermal_hot_in,
        .light_load_in, .skip_load_in, .battery_sense_input_in, .battery_low_flag_in,
        .regulation_feedback_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out, .bias_en_out,
        .precharge_out, .ss_track_out, .ref_code_out, .ls_on_out, .hs_on_out, .step_down_out,
        .hs_body_block_out, .light_load_mode_out, .battery_low_flag_out,
        .battery_low_flag_oe_out);
    bmsq_analog model_u (.sys_clk_in, .precharge_in(precharge_out), .ls_on_in(ls_on_out),
        .cmp_dly_in(dly), .exit_out(out_exit_level_in), .cmp_out(error_amp_level_in),
        .fb_out(regulation_feedback_in));
    // compare and count
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // step k edges, then sample settled outputs
    task automatic tick(input int k);
        repeat (k) @(posedge sys_clk_in);
        #1;
    endtask
    // one register cycle, read data checked in the cycle after
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [31:0] e);
        @(posedge sys_clk_in);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= w;
        rd_in <= !w;
        @(posedge sys_clk_in);
        wr_in <= 1'b0;
        rd_in <= 1'b0;
        #1;
        if (!w) chk(rdata_out, e);
    endtask
    // measure one low-side pulse: on time, rise-to-rise period
    task automatic pulse;
        n = 0;
        while (ls_on_out !== 1'b0 && n < 300) begin tick(1); n++; end
        while (ls_on_out !== 1'b1 && n < 600) begin tick(1); n++; end
        on = 0;
        while (ls_on_out === 1'b1 && on < 300) begin tick(1); on++; end
        hs_seen = hs_on_out;
        per = on;
        while (ls_on_out !== 1'b1 && per < 600) begin tick(1); per++; end
    endtask
    // count any gate activity over k clocks
    task automatic quiet(input int k);
        n = 0;
        repeat (k) begin tick(1); n += int'(ls_on_out | hs_on_out); end
    endtask
    task automatic final_report;
        $display("checks=%0d bad_count=%0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin #1_000_000; bad_count++; final_report; end
    initial begin
        n = $urandom(32'h852a_4bee);
        repeat (10) @(posedge sys_clk_in);
        rstn_in <= 1'b1;
        tick(1);
        chk({hs_body_block_out, bias_en_out, ls_on_out, battery_low_flag_oe_out}, 4'h8);
        bus(1'b0, 4'h0, 0, 32'h0000_0001);
        bus(1'b0, 4'h4, 0, 32'h0000_0100);
        bus(1'b0, 4'hc, 0, 32'h0000_0000);
        @(posedge sys_clk_in);
        chip_on_in <= 1'b1;
        battery_sense_input_in <= 1'b1;
        tick(8);
        chk({bias_en_out, battery_low_flag_oe_out}, 2'h1);
        @(posedge sys_clk_in);
        supply_lockout_rising_in <= 1'b1;
        tick(20);
        chk({bias_en_out, precharge_out, ss_track_out}, 3'h7);
        chk(regulation_feedback_in - ref_code_out <= 10'h003, 1);
        for (n = 0; precharge_out === 1'b1 && n < 200; n++) tick(1);
        for (n = 0; ref_code_out !== 10'h3ff && n < 2400; n++) tick(1);
        chk(n >= 1800 && n < 2100 && !ss_track_out, 1);
        for (int i = 0; i < 6; i++) begin
            dly <= 6'(4 + $urandom % 40);
            pulse;
            chk(per, 66);
            chk(on >= dly && on <= dly + 4 && hs_seen, 1);
        end
        dly <= 6'h3f;
        peak_limit_in <= 1'b1;
        pulse;
        chk(on <= 4 && hs_seen, 1);
        peak_limit_in <= 1'b0;
        below_margin_in <= 1'b1;
        battery_sense_input_in <= 1'b0;
        tick(4);
        chk({step_down_out, battery_low_flag_oe_out, battery_low_flag_out}, 3'h4);
        dly <= 6'h0c;
        for (int k = 0; k < 2; k++) begin
            {overvoltage_guard_in, thermal_hot_in} <= k ? 2'b01 : 2'b10;
            tick(4);
            quiet(200);
            chk(n, 0);
            {overvoltage_guard_in, thermal_hot_in} <= 2'b00;
            pulse;
            chk(per, 66);
        end
        light_load_in <= 1'b1;
        tick(300);
        chk(light_load_mode_out, 1);
        pulse;
        chk(per, 132);
        skip_load_in <= 1'b1;
        tick(140);
        quiet(300);
        chk(n, 0);
        {skip_load_in, light_load_in} <= 2'b00;
        tick(300);
        chk(light_load_mode_out, 0);
        {peak_limit_in, below_input_in} <= 2'b11;
        tick(6);
        chk({bias_en_out, ls_on_out, hs_on_out, precharge_out}, 4'h8);
        {peak_limit_in, below_input_in} <= 2'b00;
        for (n = 0; precharge_out !== 1'b1 && n < 40; n++) tick(1);
        chk(n >= 8 && n < 30, 1);
        bus(1'b0, 4'h8, 0, 32'h0000_0007);
        bus(1'b1, 4'h8, 32'h0000_0007, 0);
        bus(1'b0, 4'h8, 0, 32'h0000_0000);
        chip_on_in <= 1'b0;
        tick(4);
        chk({hs_body_block_out, bias_en_out, ls_on_out, hs_on_out, battery_low_flag_oe_out},
            5'h10);
        final_report;
    end
endmodule
`default_nettype wire
